/* rtl/fasb_pkg.sv */
// Constants for the fault alert status register bank
`default_nettype none
package fasb_pkg;
    localparam logic [7:0] FASB_ADDR_ONE = 8'h14;
    localparam logic [7:0] FASB_ADDR_TWO = 8'h18;
    localparam logic [7:0] FASB_ADDR_IRQ_STAT = 8'h20;
    localparam logic [7:0] FASB_ADDR_IRQ_MASK = 8'h24;
    localparam logic [7:0] FASB_ADDR_CTRL = 8'h28;
    localparam logic [7:0] FASB_ADDR_BAL = 8'h2c;
    localparam logic [7:0] FASB_ADDR_STATE = 8'h30;
    localparam int FASB_ONE_BITS = 9;
    localparam int FASB_TWO_LSB = 11;
    localparam int FASB_TWO_BITS = 5;
    localparam int FASB_BAL_N = 14;
    localparam int FASB_IRQ_BITS = 4;
    localparam int BIT_RAIL2 = 8;
    localparam int BIT_RAIL1 = 7;
    localparam int BIT_GND3 = 6;
    localparam int BIT_GND2 = 5;
    localparam int BIT_GND1 = 4;
    localparam int BIT_UNDER = 3;
    localparam int BIT_MARGIN = 2;
    localparam int BIT_OVER = 1;
    localparam int BIT_SUMMARY = 0;
    localparam logic [8:0] FASB_ONE_RESET = 9'h000;
    localparam logic [4:0] FASB_TWO_RESET = 5'h00;
    localparam logic [8:0] FASB_GATED_MASK = 9'h1fa;
    localparam int IRQ_ONE_SET = 0;
    localparam int IRQ_TWO_SET = 1;
    localparam int IRQ_SCAN_DONE = 2;
    localparam int IRQ_RST_ALERT = 3;
    localparam int CTRL_RST_ALERT = 0;
endpackage
`default_nettype wire

/* rtl/fasb_alert_bit.sv */
// One latched fault bit: set wins, write zero clears unless hold_cond is high
`default_nettype none
module fasb_alert_bit (
    input wire logic mclk,
    input wire logic rst,
    input wire logic set_cond,
    input wire logic hold_cond,
    input wire logic clr_req,
    output logic q
);
    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= 1'b0;
        end else if (set_cond) begin
            q <= 1'b1;
        end else if (clr_req && !hold_cond) begin
            q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* rtl/fasb_summary_bit.sv */
// Balance-switch fault summary bit, refreshed at scan end
`default_nettype none
module fasb_summary_bit #(
    parameter int N = 14
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scan_done,
    input wire logic [N-1:0] balance_switch_fault,
    input wire logic [N-1:0] balance_enable,
    input wire logic clr_req,
    output logic q
);
    logic next_q;
    always_comb begin
        next_q = |balance_switch_fault;
        if (!(|(balance_switch_fault & balance_enable))) begin
            next_q = 1'b0;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= 1'b0;
        end else if (scan_done) begin
            q <= next_q;
        end else if (clr_req) begin
            q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* rtl/fasb_top.sv */
// Fault alert status bank with Wishbone slave and interrupt
//
// Local design decision: the Wishbone interface to the registers.
`default_nettype none
module fasb_top
    import fasb_pkg::*;
#(
    parameter int BAL_N = FASB_BAL_N
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic logic_rail2_low,
    input wire logic logic_rail1_low,
    input wire logic ground3_open,
    input wire logic ground2_open,
    input wire logic ground1_open,
    input wire logic high_supply_under,
    input wire logic high_supply_margin_low,
    input wire logic measuring,
    input wire logic high_supply_over,
    input wire logic scan_done,
    input wire logic [BAL_N-1:0] balance_switch_fault,
    input wire logic [BAL_N-1:0] balance_enable,
    input wire logic user_event,
    input wire logic aux_supply_mux_event,
    input wire logic alert_retention_event,
    input wire logic temperature_event,
    input wire logic scan_timeout_event,
    input wire logic power_on_reset_event,
    output logic irq
);
    // ==========================================================
    // Bus decode
    logic req;
    logic wr;
    logic lo_wr;
    logic hi_wr;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Writes commit in the ack cycle, while the master still holds them
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign lo_wr = wb_sel_i[0];
    assign hi_wr = wb_sel_i[1];

    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // ==========================================================
    // Power-on reset alert, set at reset, cleared by zero write
    logic power_on_reset_alert;
    logic [31:0] ctrl_wdat;
    assign ctrl_wdat = wb_dat_i;
    always_ff @(posedge mclk) begin
        if (rst) begin
            power_on_reset_alert <= 1'b1;
        end else if (power_on_reset_event) begin
            power_on_reset_alert <= 1'b1;
        end else if (wr && lo_wr && wb_adr_i == FASB_ADDR_CTRL &&
                     !ctrl_wdat[CTRL_RST_ALERT]) begin
            power_on_reset_alert <= 1'b0;
        end
    end

    // ==========================================================
    // First fault register
    logic [8:0] one_q;
    logic [8:0] one_raw;
    logic [8:0] one_set;
    logic [8:0] one_hold;
    logic [8:0] one_clr;
    logic one_wr_lo;
    logic one_wr_hi;
    assign one_wr_lo = wr && lo_wr && wb_adr_i == FASB_ADDR_ONE;
    assign one_wr_hi = wr && hi_wr && wb_adr_i == FASB_ADDR_ONE;

    always_comb begin
        one_raw = FASB_ONE_RESET;
        one_raw[BIT_RAIL2] = logic_rail2_low;
        one_raw[BIT_RAIL1] = logic_rail1_low;
        one_raw[BIT_GND3] = ground3_open;
        one_raw[BIT_GND2] = ground2_open;
        one_raw[BIT_GND1] = ground1_open;
        one_raw[BIT_UNDER] = high_supply_under;
        one_raw[BIT_MARGIN] = high_supply_margin_low && measuring;
        one_raw[BIT_OVER] = high_supply_over;
        // Gated bits held off while the reset alert is pending
        one_set = one_raw &
            ~(FASB_GATED_MASK & {9{power_on_reset_alert}});
        one_hold = FASB_ONE_RESET;
        one_hold[BIT_RAIL2] = logic_rail2_low;
        one_hold[BIT_RAIL1] = logic_rail1_low;
        // Zero written clears, one written is ignored
        one_clr = ~wb_dat_i[8:0] &
            {one_wr_hi, {8{one_wr_lo}}};
    end

    fasb_alert_bit u_rail2 (
        .mclk(mclk),
        .rst(rst),
        .set_cond(one_set[BIT_RAIL2]),
        .hold_cond(one_hold[BIT_RAIL2]),
        .clr_req(one_clr[BIT_RAIL2]),
        .q(one_q[BIT_RAIL2])
    );

    fasb_alert_bit u_rail1 (
        .mclk(mclk),
        .rst(rst),
        .set_cond(one_set[BIT_RAIL1]),
        .hold_cond(one_hold[BIT_RAIL1]),
        .clr_req(one_clr[BIT_RAIL1]),
        .q(one_q[BIT_RAIL1])
    );

    fasb_alert_bit u_gnd3 (
        .mclk(mclk),
        .rst(rst),
        .set_cond(one_set[BIT_GND3]),
        .hold_cond(one_hold[BIT_GND3]),
        .clr_req(one_clr[BIT_GND3]),
        .q(one_q[BIT_GND3])
    );

    fasb_alert_bit u_gnd2 (
        .mclk(mclk),
        .rst(rst),
        .set_cond(one_set[BIT_GND2]),
        .hold_cond(one_hold[BIT_GND2]),
        .clr_req(one_clr[BIT_GND2]),
        .q(one_q[BIT_GND2])
    );

    fasb_alert_bit u_gnd1 (
        .mclk(mclk),
        .rst(rst),
        .set_cond(one_set[BIT_GND1]),
        .hold_cond(one_hold[BIT_GND1]),
        .clr_req(one_clr[BIT_GND1]),
        .q(one_q[BIT_GND1])
    );

    fasb_alert_bit u_under (
        .mclk(mclk),
        .rst(rst),
        .set_cond(one_set[BIT_UNDER]),
        .hold_cond(one_hold[BIT_UNDER]),
        .clr_req(one_clr[BIT_UNDER]),
        .q(one_q[BIT_UNDER])
    );

    fasb_alert_bit u_margin (
        .mclk(mclk),
        .rst(rst),
        .set_cond(one_set[BIT_MARGIN]),
        .hold_cond(one_hold[BIT_MARGIN]),
        .clr_req(one_clr[BIT_MARGIN]),
        .q(one_q[BIT_MARGIN])
    );

    fasb_alert_bit u_over (
        .mclk(mclk),
        .rst(rst),
        .set_cond(one_set[BIT_OVER]),
        .hold_cond(one_hold[BIT_OVER]),
        .clr_req(one_clr[BIT_OVER]),
        .q(one_q[BIT_OVER])
    );

    fasb_summary_bit #(.N(BAL_N)) u_summary (
        .mclk(mclk),
        .rst(rst),
        .scan_done(scan_done),
        .balance_switch_fault(balance_switch_fault),
        .balance_enable(balance_enable),
        .clr_req(one_clr[BIT_SUMMARY]),
        .q(one_q[BIT_SUMMARY])
    );

    // ==========================================================
    // Second fault register, upper five bits
    logic [4:0] two_q;
    logic [4:0] two_set;
    logic [4:0] two_clr;
    assign two_set = {user_event, aux_supply_mux_event,
        alert_retention_event, temperature_event, scan_timeout_event};
    assign two_clr = ~wb_dat_i[15:11] &
        {5{wr && hi_wr && wb_adr_i == FASB_ADDR_TWO}};

    // Same latch cell as the first register, no hold term
    fasb_alert_bit u_user (
        .mclk(mclk),
        .rst(rst),
        .set_cond(two_set[4]),
        .hold_cond(1'b0),
        .clr_req(two_clr[4]),
        .q(two_q[4])
    );

    fasb_alert_bit u_aux_mux (
        .mclk(mclk),
        .rst(rst),
        .set_cond(two_set[3]),
        .hold_cond(1'b0),
        .clr_req(two_clr[3]),
        .q(two_q[3])
    );

    fasb_alert_bit u_retention (
        .mclk(mclk),
        .rst(rst),
        .set_cond(two_set[2]),
        .hold_cond(1'b0),
        .clr_req(two_clr[2]),
        .q(two_q[2])
    );

    fasb_alert_bit u_temp (
        .mclk(mclk),
        .rst(rst),
        .set_cond(two_set[1]),
        .hold_cond(1'b0),
        .clr_req(two_clr[1]),
        .q(two_q[1])
    );

    fasb_alert_bit u_timeout (
        .mclk(mclk),
        .rst(rst),
        .set_cond(two_set[0]),
        .hold_cond(1'b0),
        .clr_req(two_clr[0]),
        .q(two_q[0])
    );

    // ==========================================================
    // Interrupt status and mask
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [3:0] irq_ev;
    logic [3:0] irq_clr;
    assign irq_ev = {power_on_reset_event, scan_done,
        |two_set, |one_set[8:1]};
    assign irq_clr = wb_dat_i[3:0] &
        {4{wr && lo_wr && wb_adr_i == FASB_ADDR_IRQ_STAT}};

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_stat <= 4'h0;
        end else begin
            irq_stat <= irq_ev | (irq_stat & ~irq_clr);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_mask <= 4'h0;
        end else if (wr && lo_wr && wb_adr_i == FASB_ADDR_IRQ_MASK) begin
            irq_mask <= wb_dat_i[3:0];
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ==========================================================
    // Read data
    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                FASB_ADDR_ONE: begin
                    wb_dat_o <= {23'h000000, one_q};
                end
                FASB_ADDR_TWO: begin
                    wb_dat_o <= {16'h0000, two_q, 11'h000};
                end
                FASB_ADDR_IRQ_STAT: begin
                    wb_dat_o <= {28'h0000000, irq_stat};
                end
                FASB_ADDR_IRQ_MASK: begin
                    wb_dat_o <= {28'h0000000, irq_mask};
                end
                FASB_ADDR_CTRL: begin
                    wb_dat_o <= {31'h00000000, power_on_reset_alert};
                end
                FASB_ADDR_BAL: begin
                    wb_dat_o <= 32'(balance_switch_fault);
                end
                default: begin
                    wb_dat_o <= 32'h0000_0000;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* dv/fasb_checker.sv */
// Checker for the fault alert status bank
`default_nettype none
module fasb_checker
    import fasb_pkg::*;
#(
    parameter int BAL_N = 14
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic scan_done,
    input wire logic [BAL_N-1:0] balance_switch_fault,
    input wire logic [BAL_N-1:0] balance_enable,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic clr_seen, sum_exp, mask_on;
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr = wb_ack_o && wb_we_i;
    wire logic rd = wb_ack_o && !wb_we_i;
    wire logic rd1 = rd && wb_adr_i == FASB_ADDR_ONE;
    wire logic rd2 = rd && wb_adr_i == FASB_ADDR_TWO;
    wire logic rdc = rd && wb_adr_i == FASB_ADDR_CTRL;
    // ========================================
    // Expected alert, summary and mask state
    always_ff @(posedge mclk) begin
        if (rst) begin
            clr_seen <= 1'h0;
            sum_exp <= 1'h0;
            mask_on <= 1'h0;
        end else begin
            if (wr && wb_adr_i == FASB_ADDR_CTRL && !wb_dat_i[0])
                clr_seen <= 1'h1;
            if (scan_done)
                sum_exp <= |(balance_switch_fault & balance_enable);
            else if (wr && wb_adr_i == FASB_ADDR_ONE && !wb_dat_i[0])
                sum_exp <= 1'h0;
            if (wr && wb_adr_i == FASB_ADDR_IRQ_MASK)
                mask_on <= |wb_dat_i[3:0];
        end
    end
    // ========================================
    // Properties
    property p_ack_resp; req |=> wb_ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack late");
    property p_ack_pulse; $rose(wb_ack_o) |=> $fell(wb_ack_o); endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_one_top; rd1 |-> wb_dat_o[31:9] == 23'h0; endproperty
    a_one_top: assert property (p_one_top) else $error("upper bits set");
    property p_gated;
        rd1 && !clr_seen |-> !(|(wb_dat_o[8:1] & 8'hfd));
    endproperty
    a_gated: assert property (p_gated) else $error("gated bit set");
    property p_summary;
        rd1 |-> wb_dat_o[0] == $past(sum_exp);
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary");
    property p_two_free; rd2 |-> wb_dat_o[10:0] == 11'h0; endproperty
    a_two_free: assert property (p_two_free) else $error("spare bits");
    property p_alert_pend; rdc && !clr_seen |-> wb_dat_o[0]; endproperty
    a_alert_pend: assert property (p_alert_pend) else $error("alert lost");
    property p_irq_mask; !mask_on |-> !irq; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq masked");
    c_sum: cover property (rd1 && wb_dat_o[0]);
    c_irq: cover property (irq);
    c_clr: cover property (rdc && clr_seen);
endmodule
bind fasb_top fasb_checker #(.BAL_N(BAL_N)) u_chk (.mclk(mclk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .scan_done(scan_done), .irq(irq),
    .balance_switch_fault(balance_switch_fault),
    .balance_enable(balance_enable));
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the fault alert status bank
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    err_total++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top import fasb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic sd = 1'h0, meas = 1'h0, por = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [8:1] f = 8'h00;
    logic [4:0] ev = 5'h00;
    logic [13:0] bal = 14'h0000, en = 14'h0000;
    logic [31:0] dat = 32'h0, q;
    wire logic [31:0] dout;
    wire logic ack, irq;
    int err_total = 0, checks_done = 0;
    always #2.5 mclk = ~mclk;
    fasb_top DUT (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
        .wb_dat_o(dout), .wb_ack_o(ack), .logic_rail2_low(f[8]),
        .logic_rail1_low(f[7]), .ground3_open(f[6]), .ground2_open(f[5]),
        .ground1_open(f[4]), .high_supply_under(f[3]),
        .high_supply_margin_low(f[2]), .measuring(meas),
        .high_supply_over(f[1]), .scan_done(sd), .balance_switch_fault(bal),
        .balance_enable(en), .user_event(ev[4]),
        .aux_supply_mux_event(ev[3]), .alert_retention_event(ev[2]),
        .temperature_event(ev[1]), .scan_timeout_event(ev[0]),
        .power_on_reset_event(por), .irq(irq));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'h1 && n < 20);
        q = dout;
        cyc <= 1'h0;
        stb <= 1'h0;
        if (n >= 20) begin
            err_total++;
            finish_test();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        `CHK($sformatf("addr %h", a), e, q)
    endtask
    task automatic scan;
        @(posedge mclk);
        sd <= 1'h1;
        @(posedge mclk);
        sd <= 1'h0;
    endtask
    task automatic t_reset;
        f <= 8'hff;
        rd(FASB_ADDR_ONE, 32'h0);
        rd(FASB_ADDR_TWO, 32'h0);
        rd(FASB_ADDR_CTRL, 32'h1);
        rd(FASB_ADDR_IRQ_MASK, 32'h0);
        rd(8'h3c, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_faults;
        wb(1'h1, FASB_ADDR_CTRL, 32'h0);
        meas <= 1'h1;
        repeat (2) @(posedge mclk);
        rd(FASB_ADDR_ONE, 32'h1fe);
        f <= 8'h80;
        meas <= 1'h0;
        wb(1'h1, FASB_ADDR_ONE, 32'h1ff);
        rd(FASB_ADDR_ONE, 32'h1fe);
        wb(1'h1, FASB_ADDR_ONE, 32'h0);
        rd(FASB_ADDR_ONE, 32'h100);
        f <= 8'h00;
        wb(1'h1, FASB_ADDR_ONE, 32'h0);
        rd(FASB_ADDR_ONE, 32'h0);
        $display("t_faults done");
    endtask
    task automatic t_summary;
        bal <= 14'h2000;
        en <= 14'h3fff;
        scan();
        rd(FASB_ADDR_ONE, 32'h1);
        bal <= 14'h0000;
        repeat (3) @(posedge mclk);
        rd(FASB_ADDR_ONE, 32'h1);
        scan();
        rd(FASB_ADDR_ONE, 32'h0);
        bal <= 14'h0001;
        scan();
        rd(FASB_ADDR_ONE, 32'h1);
        rd(FASB_ADDR_BAL, 32'h1);
        wb(1'h1, FASB_ADDR_ONE, 32'h0);
        rd(FASB_ADDR_ONE, 32'h0);
        en <= 14'h0000;
        scan();
        rd(FASB_ADDR_ONE, 32'h0);
        $display("t_summary done");
    endtask
    task automatic t_second;
        logic [31:0] e;
        e = 32'h0;
        for (int i = 0; i < 5; i++) begin
            ev <= 5'h01 << i;
            @(posedge mclk);
            ev <= 5'h00;
            e = e | (32'h800 << i);
            rd(FASB_ADDR_TWO, e);
        end
        wb(1'h1, FASB_ADDR_TWO, 32'hff00);
        rd(FASB_ADDR_TWO, 32'hf800);
        wb(1'h1, FASB_ADDR_TWO, 32'h0);
        rd(FASB_ADDR_TWO, 32'h0);
        $display("t_second done");
    endtask
    task automatic t_irq;
        rd(FASB_ADDR_IRQ_STAT, 32'h7);
        wb(1'h1, FASB_ADDR_IRQ_MASK, 32'h2);
        @(posedge mclk);
        `CHK("irq on", 1'h1, irq)
        wb(1'h1, FASB_ADDR_IRQ_MASK, 32'hf);
        wb(1'h1, FASB_ADDR_IRQ_STAT, 32'hf);
        @(posedge mclk);
        `CHK("irq cleared", 1'h0, irq)
        por <= 1'h1;
        @(posedge mclk);
        por <= 1'h0;
        @(posedge mclk);
        `CHK("irq reset alert", 1'h1, irq)
        rd(FASB_ADDR_IRQ_STAT, 32'h8);
        rd(FASB_ADDR_CTRL, 32'h1);
        $display("t_irq done");
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        t_reset();
        t_faults();
        t_summary();
        t_second();
        t_irq();
        finish_test();
    end
endmodule
`default_nettype wire
